// File: pkg/hms_consts.svh
`ifndef HMS_CONSTS_SVH
`define HMS_CONSTS_SVH

// ==========================================
// widths
`define HMS_MODE_W        6
`define HMS_POS_W         32
`define HMS_FAULT_W       16

// ==========================================
// mode codes
`define HMS_MODE_NONE     6'h00
`define HMS_MODE_LO_LAST  6'h0e
`define HMS_MODE_HI_FIRST 6'h11
`define HMS_MODE_HI_LAST  6'h1e
`define HMS_MODE_HI_SHIFT 6'h10
`define HMS_MODE_IDX_NEG  6'h21
`define HMS_MODE_IDX_POS  6'h22
`define HMS_MODE_LOAD     6'h23

// ==========================================
// base code layout (modes 1..14)
`define HMS_BASE_LIM_NEG  6'h01
`define HMS_BASE_LIM_POS  6'h02
`define HMS_BASE_REV_1ST  6'h07
// per-base bit masks: bit n belongs to base n
`define HMS_MASK_DIR_POS  16'h079c
`define HMS_MASK_EDGE_R   16'h1e60
`define HMS_MASK_SIDE_R   16'h2d30

// ==========================================
// fault reporting: group 14, code 45
`define HMS_FAULT_CODE    16'h1445
`define HMS_FAULT_NONE    16'h0000

`endif

// File: pkg/hms_pkg.sv
package hms_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEEK = 2'b01,
		ST_IDX  = 2'b10
	} hms_state_t;

	typedef enum logic [2:0] {
		K_IDLE  = 3'b000,
		K_LIMIT = 3'b001,
		K_HOME  = 3'b010,
		K_INDEX = 3'b011,
		K_LOAD  = 3'b100
	} hms_kind_t;

endpackage

// File: rtl/hms_mode_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "hms_consts.svh"

module hms_mode_dec
	import hms_pkg::*;
(
	input  wire logic [`HMS_MODE_W-1:0] mode,
	output var  logic                   valid,
	output var  hms_kind_t              kind,
	output var  logic                   dir_pos,
	output var  logic                   rev_ok,
	output var  logic                   edge_r,
	output var  logic                   side_r,
	output var  logic                   use_idx
);

	// ==========================================
	// fold modes 17..30 onto 1..14
	logic                   hi;
	logic                   lo;
	logic [`HMS_MODE_W-1:0] base;
	logic [3:0]             bsel;
	logic                   is_lim;
	logic                   is_idx;
	// a literal cannot be bit-selected, so the masks sit on named wires
	logic [15:0]            msk_dir;
	logic [15:0]            msk_edge;
	logic [15:0]            msk_side;

	assign msk_dir  = `HMS_MASK_DIR_POS;
	assign msk_edge = `HMS_MASK_EDGE_R;
	assign msk_side = `HMS_MASK_SIDE_R;

	assign hi      = (mode >= `HMS_MODE_HI_FIRST) && (mode <= `HMS_MODE_HI_LAST);
	assign lo      = (mode != `HMS_MODE_NONE) && (mode <= `HMS_MODE_LO_LAST);
	assign base    = hi ? mode - `HMS_MODE_HI_SHIFT : mode; // RQ8
	assign bsel    = base[3:0];
	assign is_lim  = (base == `HMS_BASE_LIM_NEG) || (base == `HMS_BASE_LIM_POS); // RQ9
	assign is_idx  = (mode == `HMS_MODE_IDX_NEG) || (mode == `HMS_MODE_IDX_POS);

	// codes 15, 16, 31, 32 and above 35 fall out here
	assign valid   = (mode == `HMS_MODE_NONE) || lo || hi || is_idx || (mode == `HMS_MODE_LOAD); // RQ17

	assign kind    = (mode == `HMS_MODE_NONE) ? K_IDLE :  // RQ1
	                 (mode == `HMS_MODE_LOAD) ? K_LOAD :  // RQ14
	                 is_idx                  ? K_INDEX : // RQ13
	                 is_lim                  ? K_LIMIT : K_HOME;

	// dir (except in modes 33 and 34) and edge/side selection from per-base masks
	assign dir_pos = is_idx ? (mode == `HMS_MODE_IDX_POS) : msk_dir[bsel]; // RQ2 RQ3 RQ4 RQ5 RQ10
	assign rev_ok  = (base >= `HMS_BASE_REV_1ST); // RQ6 RQ7 RQ11 RQ12
	assign edge_r  = msk_edge[bsel];
	assign side_r  = msk_side[bsel];
	assign use_idx = lo; // RQ8

endmodule
`default_nettype wire

// File: rtl/hms_top.sv
// Behaviour
// [RQ1] Mode 0 is the reset default and a start in it moves nothing and leaves the position count alone.
// [RQ2] Mode 1 drives to the negative limit switch and takes the next index pulse there as reference.
// [RQ3] Mode 2 drives to the positive limit switch and takes the next index pulse there as reference.
// [RQ4] Modes 3 and 4 search positive for the home switch and take the first index left or right of its edge.
// [RQ5] Modes 5 and 6 search negative for the home switch and take the first index right or left of its edge.
// [RQ6] Modes 7 to 10 search positive, reverse at the positive limit, and reference on the chosen index.
// [RQ7] Modes 11 to 14 search negative, reverse at the negative limit, and reference on the chosen index.
// [RQ8] Modes 17 to 30 repeat modes 1 to 14 but reference at the switch event without an index pulse.
// [RQ9] Modes 17 and 18 reference directly at the negative or positive limit switch.
// [RQ10] Modes 19 to 22 reference at the home switch edge reached moving positive or negative.
// [RQ11] Modes 23 to 26 search positive for the chosen home edge and reverse at the positive limit.
// [RQ12] Modes 27 to 30 search negative for the chosen home edge and reverse at the negative limit.
// [RQ13] Modes 33 and 34 reference on the first index pulse met moving negative or positive.
// [RQ14] Mode 35 moves nothing and loads the home offset into the position count at once.
// [RQ15] Both limit switches active together raise fault code 45 of the limit group and stop motion.
// [RQ16] A finished search loads the home offset into the position count and sets homing done.
// [RQ17] Undefined mode codes are refused at start.
`timescale 1ns/1ps
`default_nettype none
`include "hms_consts.svh"

module hms_top
	import hms_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    arst_n,
	input  wire logic [`HMS_MODE_W-1:0]  mode,
	input  wire logic                    start,
	input  wire logic [`HMS_POS_W-1:0]   home_offset,
	input  wire logic                    lim_pos,
	input  wire logic                    lim_neg,
	input  wire logic                    home_sw,
	input  wire logic                    index_pulse,
	output var  logic                    move_pos_ff,
	output var  logic                    move_neg_ff,
	output var  logic                    busy_ff,
	output var  logic                    done_ff,
	output var  logic                    fail_ff,
	output var  logic                    refused_ff,
	output var  logic                    fault_ff,
	output var  logic [`HMS_FAULT_W-1:0] fault_code_ff,
	output var  logic                    load_ff,
	output var  logic [`HMS_POS_W-1:0]   load_val_ff
);

	// ==========================================
	// reset release
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ==========================================
	// mode decode
	logic      dec_valid;
	hms_kind_t dec_kind;
	logic      dec_dir;
	logic      dec_rev;
	logic      dec_edge;
	logic      dec_side;
	logic      dec_idx;

	hms_mode_dec u_dec (
		.mode    (mode),
		.valid   (dec_valid),
		.kind    (dec_kind),
		.dir_pos (dec_dir),
		.rev_ok  (dec_rev),
		.edge_r  (dec_edge),
		.side_r  (dec_side),
		.use_idx (dec_idx)
	);

	// ==========================================
	// state
	hms_state_t st_ff;
	hms_state_t nxt_st;
	hms_kind_t  cfg_kind_ff;
	hms_kind_t  nxt_kind;
	logic       cfg_rev_ff;
	logic       cfg_edge_ff;
	logic       cfg_side_ff;
	logic       cfg_idx_ff;
	logic       dir_ff;
	logic       rev_done_ff;
	logic       home_q_ff;
	logic       nxt_rev;
	logic       nxt_edge;
	logic       nxt_side;
	logic       nxt_idx;
	logic       nxt_dir;
	logic       nxt_rev_done;
	logic       nxt_done;
	logic       nxt_fail;
	logic       nxt_refused;
	logic       nxt_fault;
	logic       nxt_load;
	logic       hit_ref;
	logic       give_up;

	// ==========================================
	// switch events
	logic both_lim;
	logic lim_ahead;
	logic home_ent;
	logic home_lev;
	logic edge_is_r;
	logic edge_match;
	logic go_now;

	assign both_lim   = lim_pos && lim_neg;
	assign lim_ahead  = dir_ff ? lim_pos : lim_neg;
	assign home_ent   = home_sw && !home_q_ff;
	assign home_lev   = !home_sw && home_q_ff;
	// entering while moving positive is the left edge, leaving is the right
	assign edge_is_r  = dir_ff ? home_lev : home_ent;
	assign edge_match = (home_ent || home_lev) && (edge_is_r == cfg_edge_ff);
	assign go_now     = (st_ff == ST_IDLE) && start;

	always_comb begin
		nxt_st       = st_ff;
		nxt_kind     = cfg_kind_ff;
		nxt_rev      = cfg_rev_ff;
		nxt_edge     = cfg_edge_ff;
		nxt_side     = cfg_side_ff;
		nxt_idx      = cfg_idx_ff;
		nxt_dir      = dir_ff;
		nxt_rev_done = rev_done_ff;
		nxt_done     = done_ff;
		nxt_fail     = fail_ff;
		nxt_fault    = fault_ff;
		nxt_refused  = 1'b0;
		hit_ref      = 1'b0;
		give_up      = 1'b0;
		unique case (st_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_done  = 1'b0;
					nxt_fail  = 1'b0;
					nxt_fault = 1'b0;
					if (!dec_valid) begin
						nxt_refused = 1'b1; // RQ17
					end else if (dec_kind == K_LOAD) begin
						hit_ref = 1'b1; // RQ14
					end else if (dec_kind != K_IDLE) begin
						nxt_st       = ST_SEEK;
						nxt_kind     = dec_kind;
						nxt_dir      = dec_dir;
						nxt_rev      = dec_rev;
						nxt_edge     = dec_edge;
						nxt_side     = dec_side;
						nxt_idx      = dec_idx;
						nxt_rev_done = 1'b0;
					end
				end
			end
			ST_SEEK: begin
				if (cfg_kind_ff == K_INDEX) begin
					hit_ref = index_pulse; // RQ13
				end else if (cfg_kind_ff == K_LIMIT) begin
					if (lim_ahead && cfg_idx_ff) begin
						// back off the limit and wait for the index
						nxt_dir = !dir_ff; // RQ2 RQ3
						nxt_st  = ST_IDX;
					end else if (lim_ahead) begin
						hit_ref = 1'b1; // RQ9
					end
				end else if (edge_match && cfg_idx_ff) begin
					nxt_dir = cfg_side_ff; // RQ4 RQ5 RQ6 RQ7
					nxt_st  = ST_IDX;
				end else if (edge_match) begin
					hit_ref = 1'b1; // RQ10 RQ11 RQ12
				end else if (lim_ahead && cfg_rev_ff && !rev_done_ff) begin
					nxt_dir      = !dir_ff; // RQ6 RQ7 RQ11 RQ12
					nxt_rev_done = 1'b1;
				end else if (lim_ahead) begin
					give_up = 1'b1;
				end
			end
			ST_IDX: begin
				if (index_pulse) begin
					hit_ref = 1'b1;
				end else if (lim_ahead) begin
					give_up = 1'b1;
				end
			end
			default: begin
				give_up = 1'b1;
			end
		endcase
		if (hit_ref) begin
			nxt_st   = ST_IDLE; // RQ16
			nxt_done = 1'b1;
		end
		if (give_up) begin
			nxt_st   = ST_IDLE;
			nxt_fail = 1'b1;
		end
		// fault wins over a start or a clear in the same cycle
		if (both_lim) begin
			nxt_fault = 1'b1; // RQ15
			nxt_st    = ST_IDLE;
			nxt_done  = 1'b0;
			nxt_fail  = (st_ff != ST_IDLE) || fail_ff;
			hit_ref   = 1'b0;
		end
		nxt_load = hit_ref;
	end

	// ==========================================
	// registers
	logic moving;

	assign moving = (nxt_st != ST_IDLE);

	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			st_ff       <= ST_IDLE;
			cfg_kind_ff <= K_IDLE;
			cfg_rev_ff  <= 1'b0;
			cfg_edge_ff <= 1'b0;
			cfg_side_ff <= 1'b0;
			cfg_idx_ff  <= 1'b0;
			dir_ff      <= 1'b0;
			rev_done_ff <= 1'b0;
			home_q_ff   <= 1'b0;
		end else begin
			st_ff       <= nxt_st;
			cfg_kind_ff <= nxt_kind;
			cfg_rev_ff  <= nxt_rev;
			cfg_edge_ff <= nxt_edge;
			cfg_side_ff <= nxt_side;
			cfg_idx_ff  <= nxt_idx;
			dir_ff      <= nxt_dir;
			rev_done_ff <= nxt_rev_done;
			home_q_ff   <= home_sw;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			move_pos_ff   <= 1'b0;
			move_neg_ff   <= 1'b0;
			busy_ff       <= 1'b0;
			done_ff       <= 1'b0;
			fail_ff       <= 1'b0;
			refused_ff    <= 1'b0;
			fault_ff      <= 1'b0;
			fault_code_ff <= `HMS_FAULT_NONE;
			load_ff       <= 1'b0;
			load_val_ff   <= '0;
		end else begin
			move_pos_ff   <= moving && nxt_dir;
			move_neg_ff   <= moving && !nxt_dir;
			busy_ff       <= moving;
			done_ff       <= nxt_done;
			fail_ff       <= nxt_fail;
			refused_ff    <= nxt_refused;
			fault_ff      <= nxt_fault;
			fault_code_ff <= nxt_fault ? `HMS_FAULT_CODE : `HMS_FAULT_NONE; // RQ15
			load_ff       <= nxt_load; // RQ16
			// offset taken at the reference cycle, not at start
			load_val_ff   <= nxt_load ? home_offset : load_val_ff; // RQ14 RQ16
		end
	end

	// ==========================================
	// checks
	sequence s_start_ok(logic [`HMS_MODE_W-1:0] m);
		go_now && !both_lim && (mode == m);
	endsequence

	property p_both_lim;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		both_lim |=> fault_ff && (fault_code_ff == `HMS_FAULT_CODE) && !move_pos_ff && !move_neg_ff;
	endproperty
	a_both_lim: assert property (p_both_lim) else $error("limit fault not raised"); // RQ15

	property p_mode0;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		s_start_ok(`HMS_MODE_NONE) |=> (!load_ff && !busy_ff) [*2];
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 moved or loaded"); // RQ1

	property p_load_now;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		s_start_ok(`HMS_MODE_LOAD) |=> load_ff && done_ff && !busy_ff && (load_val_ff == $past(home_offset));
	endproperty
	a_load_now: assert property (p_load_now) else $error("mode 35 load wrong"); // RQ14

	property p_refuse;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		go_now && !both_lim && !dec_valid |=> refused_ff && !busy_ff && !load_ff ##1 !refused_ff;
	endproperty
	a_refuse: assert property (p_refuse) else $error("undefined mode not refused"); // RQ17

	property p_dir_neg;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		go_now && !both_lim && dec_valid && (dec_kind != K_IDLE) && (dec_kind != K_LOAD) && !dec_dir
		|=> move_neg_ff && !move_pos_ff;
	endproperty
	a_dir_neg: assert property (p_dir_neg) else $error("negative search not started"); // RQ2 RQ5 RQ7 RQ13

	property p_dir_pos;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		(s_start_ok(6'h02) or s_start_ok(6'h03) or s_start_ok(6'h07) or s_start_ok(`HMS_MODE_IDX_POS))
		|=> move_pos_ff && busy_ff;
	endproperty
	a_dir_pos: assert property (p_dir_pos) else $error("positive search not started"); // RQ3 RQ4 RQ6 RQ13

	property p_done_load;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		load_ff |-> done_ff && !busy_ff && !$past(load_ff);
	endproperty
	a_done_load: assert property (p_done_load) else $error("load without done"); // RQ16

	property p_no_idx_wait;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		(st_ff == ST_IDX) |-> cfg_idx_ff && (cfg_kind_ff != K_INDEX);
	endproperty
	a_no_idx_wait: assert property (p_no_idx_wait) else $error("index wait in direct mode"); // RQ8

	property p_lim_direct;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		(st_ff == ST_SEEK) && (cfg_kind_ff == K_LIMIT) && !cfg_idx_ff && lim_ahead && !both_lim
		|=> load_ff && done_ff;
	endproperty
	a_lim_direct: assert property (p_lim_direct) else $error("limit reference missed"); // RQ9

	property p_reverse;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		(st_ff == ST_SEEK) && (cfg_kind_ff == K_HOME) && cfg_rev_ff && !rev_done_ff && lim_ahead
		&& !edge_match && !both_lim |=> (dir_ff != $past(dir_ff)) && busy_ff;
	endproperty
	a_reverse: assert property (p_reverse) else $error("no reversal at limit"); // RQ6 RQ7 RQ11 RQ12

	property p_edge_direct;
		@(posedge ref_clk) disable iff (!rst_n_ff)
		(st_ff == ST_SEEK) && (cfg_kind_ff == K_HOME) && !cfg_idx_ff && edge_match && !both_lim
		|=> load_ff ##1 !load_ff;
	endproperty
	a_edge_direct: assert property (p_edge_direct) else $error("edge reference missed"); // RQ10

endmodule
`default_nettype wire

// File: tb/hms_axis_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// axis model: one count per cycle of motion
module hms_axis_model #(
	parameter int LIM_AT  = 70,
	parameter int HOME_LO = 20,
	parameter int HOME_HI = 35
) (
	input  wire logic               ref_clk,
	input  wire logic               move_pos,
	input  wire logic               move_neg,
	input  wire logic               set_en,
	input  wire logic signed [31:0] set_val,
	input  wire logic               both_lim,
	output var  logic               lim_pos,
	output var  logic               lim_neg,
	output var  logic               home_sw,
	output var  logic               index_pulse,
	output var  logic signed [31:0] pos
);
	always_ff @(posedge ref_clk) begin
		if (set_en) begin
			pos <= set_val;
		end else if (move_pos && !move_neg) begin
			pos <= pos + 1;
		end else if (move_neg && !move_pos) begin
			pos <= pos - 1;
		end
	end

	// sensors lag the shaft by one cycle, so the sequencer always overshoots a little
	always_ff @(posedge ref_clk) begin
		lim_pos     <= both_lim || (pos >= LIM_AT);
		lim_neg     <= both_lim || (pos <= -LIM_AT);
		home_sw     <= (pos >= HOME_LO) && (pos <= HOME_HI);
		index_pulse <= (pos[3:0] == 4'h0);
	end
endmodule

`default_nettype wire

// File: tb/homing_mode_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hms_consts.svh"

module homing_mode_sequencer_tb_top;
	logic                    ref_clk;
	logic                    arst_n;
	logic [`HMS_MODE_W-1:0]  mode;
	logic                    start;
	logic [`HMS_POS_W-1:0]   home_offset;
	logic                    lim_pos;
	logic                    lim_neg;
	logic                    home_sw;
	logic                    index_pulse;
	logic                    move_pos_ff;
	logic                    move_neg_ff;
	logic                    busy_ff;
	logic                    done_ff;
	logic                    fail_ff;
	logic                    refused_ff;
	logic                    fault_ff;
	logic [`HMS_FAULT_W-1:0] fault_code_ff;
	logic                    load_ff;
	logic [`HMS_POS_W-1:0]   load_val_ff;
	logic                    set_en;
	logic signed [31:0]      set_val;
	logic                    both_lim;
	logic signed [31:0]      pos;
	int                      err_total;
	int                      checked;
	// reference point expected per mode, home switch 20..35, limits at +-70
	int exp_ref [0:34] = '{0, -64, 64, 16, 32, 48, 32, 16, 32, 32, 48, 48, 32, 32, 16, 0, 0,
		-70, 70, 20, 20, 35, 35, 20, 20, 35, 35, 35, 35, 20, 20, 0, 0, 48, 64};

	hms_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .mode(mode), .start(start), .home_offset(home_offset),
		.lim_pos(lim_pos), .lim_neg(lim_neg), .home_sw(home_sw), .index_pulse(index_pulse),
		.move_pos_ff(move_pos_ff), .move_neg_ff(move_neg_ff), .busy_ff(busy_ff), .done_ff(done_ff),
		.fail_ff(fail_ff), .refused_ff(refused_ff), .fault_ff(fault_ff), .fault_code_ff(fault_code_ff),
		.load_ff(load_ff), .load_val_ff(load_val_ff));

	hms_axis_model axis (.ref_clk(ref_clk), .move_pos(move_pos_ff), .move_neg(move_neg_ff), .set_en(set_en),
		.set_val(set_val), .both_lim(both_lim), .lim_pos(lim_pos), .lim_neg(lim_neg), .home_sw(home_sw),
		.index_pulse(index_pulse), .pos(pos));

	always #25 ref_clk = ~ref_clk;

	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			err_total = err_total + 1;
		end
	endtask

	task automatic finish_test();
		$display("counts: checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic settle();
		@(posedge ref_clk);
		#1;
	endtask

	// park the axis, then one start pulse; returns when the answer is visible
	task automatic kick(input int m, input int p);
		@(posedge ref_clk);
		set_en  <= 1'b1;
		set_val <= p;
		@(posedge ref_clk);
		set_en <= 1'b0;
		repeat (3) @(posedge ref_clk);
		mode        <= 6'(m);
		home_offset <= 32'ha5a5_0000 | 32'(m);
		start       <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		// answer is launched at this edge; look just after it
		#1;
	endtask

	// never both drive directions at once
	always @(negedge ref_clk) begin
		if (move_pos_ff === 1'b1 && move_neg_ff === 1'b1) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, 2'b11, 2'b00);
			err_total = err_total + 1;
		end
	end

	// ==========================================
	// scenarios
	task automatic test_reset();
		chk({move_pos_ff, move_neg_ff, busy_ff, done_ff, fail_ff, refused_ff, fault_ff, load_ff}, 32'h0000_0000);
		chk(fault_code_ff, `HMS_FAULT_NONE);
		$display("test reset done");
	endtask

	task automatic test_load_now();
		kick(35, 2);
		chk(load_ff, 1'b1);
		chk(load_val_ff, 32'ha5a5_0023);
		chk({done_ff, busy_ff, move_pos_ff, move_neg_ff}, 4'h8);
		settle();
		chk(load_ff, 1'b0);
		$display("test load in place done");
	endtask

	task automatic test_no_homing();
		kick(0, 2);
		repeat (4) settle();
		chk({busy_ff, move_pos_ff, move_neg_ff, load_ff, done_ff}, 5'h00);
		chk(pos, 32'h0000_0002);
		$display("test mode zero done");
	endtask

	task automatic test_searches();
		int n;
		int d;
		int p;
		for (int m = 1; m <= 34; m++) begin
			if (m == 15 || m == 16 || m == 31 || m == 32) begin
				continue;
			end
			p = ((m >= 5 && m <= 10) || (m >= 21 && m <= 26) || m >= 33) ? 50 : 2;
			kick(m, p);
			n = 0;
			while (load_ff !== 1'b1 && n < 3000) begin
				settle();
				n++;
			end
			if (n >= 3000) begin
				$display("FAIL t=%0t got=%h exp=%h", $time, load_ff, 1'b1);
				err_total = err_total + 1;
				finish_test();
			end
			chk(load_val_ff, 32'ha5a5_0000 | 32'(m));
			chk({done_ff, busy_ff, move_pos_ff, move_neg_ff}, 4'h8);
			// sensor lag gives a few counts of slack; indices are 16 apart
			d = pos - exp_ref[m];
			checked = checked + 1;
			if (d < -5 || d > 5) begin
				$display("FAIL t=%0t got=%h exp=%h", $time, pos, exp_ref[m]);
				err_total = err_total + 1;
			end
		end
		$display("test search modes done");
	endtask

	task automatic test_fault();
		kick(34, 2);
		settle();
		@(posedge ref_clk);
		both_lim <= 1'b1;
		repeat (4) settle();
		chk(fault_ff, 1'b1);
		chk(fault_code_ff, `HMS_FAULT_CODE);
		chk({busy_ff, move_pos_ff, move_neg_ff, done_ff, load_ff}, 5'h00);
		chk(fail_ff, 1'b1);
		@(posedge ref_clk);
		both_lim <= 1'b0;
		repeat (3) settle();
		kick(35, 2);
		chk({fault_ff, load_ff}, 2'b01);
		chk(fault_code_ff, `HMS_FAULT_NONE);
		$display("test limit fault done");
	endtask

	task automatic test_refused();
		int bad [6] = '{15, 16, 31, 32, 36, 63};
		foreach (bad[i]) begin
			kick(bad[i], 2);
			chk({refused_ff, busy_ff, load_ff, move_pos_ff, move_neg_ff}, 5'h10);
			settle();
			chk(refused_ff, 1'b0);
		end
		$display("test undefined modes done");
	endtask

	// ==========================================
	// main sequence
	initial begin
		ref_clk     = 1'b0;
		arst_n      = 1'b0;
		mode        = 6'h00;
		start       = 1'b0;
		home_offset = 32'h0000_0000;
		set_en      = 1'b1;
		set_val     = 32'sh0000_0002;
		both_lim    = 1'b0;
		err_total   = 0;
		checked     = 0;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		set_en <= 1'b0;
		settle();
		test_reset();
		test_load_now();
		test_no_homing();
		test_searches();
		test_fault();
		test_refused();
		finish_test();
	end
endmodule

`default_nettype wire
